// File: src/programmable_logic_block.sv
// How it works
// - inversion bits 5,4,3 invert inputs C,B,A
// - bit 6 inverts the cell output
// - 3-bit select picks off/and/or/xor/ff/pass
// - flip-flop set control forces flip-flop high unless clear is also set
// - flip-flop clear control forces flip-flop low
// - bypass bit 0 debounces output before events
// - bypass bit 1 feeds output straight through
// - events only recorded while event enable set
// - level bit chooses active low or high
// - row-3 extension routes row-3 pin to C
// - row-0 extension drives cell output on row-0
module programmable_logic_block #(
  parameter int DBNC_CYCLES = logic_block_pkg::DBNC_CYCLES,
  parameter int DBNC_CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // logic inputs
  input wire logic logic_in_a,
  input wire logic logic_in_b,
  input wire logic logic_in_c,
  // row-3 pad input
  input wire logic row3_pin_in,
  // row-0 pad, general purpose side
  input wire logic gpio1_out,
  input wire logic gpio1_oe,
  // row-0 pad drive
  output logic row0_pin_out,
  output logic row0_pin_oe,
  // cell output and event side
  output logic logic_out,
  output logic logic_filtered,
  output logic event_valid,
  output logic event_active,
  output logic int_req
);

  // every flop of the block outside the debounce stage in one word; one comb process fills the copy
  typedef struct packed {
    logic [7:0] func_cfg;
    logic [7:0] ff_ctrl;
    logic [7:0] evt_cfg;
    logic [7:0] pin_cfg_c;
    logic [7:0] rdata;
    logic rvalid;
    logic ff_q;
    logic b_prev;
    logic cell_out;
    logic filt_q;
    logic_block_pkg::evt_state_t evt;
    logic evt_valid;
    logic evt_active;
    logic irq;
    logic row0_out;
    logic row0_oe;
  } blk_state_t;

  blk_state_t st_r;
  blk_state_t st_nxt;

  logic dbnc_out;

  // combinational helpers
  logic in_a;
  logic in_b;
  logic in_c_raw;
  logic in_c;
  logic cell_raw;
  logic cell_val;
  logic out_active;
  logic [2:0] sel;
  logic [7:0] rd_mux;

  // per-input vectors for the inversion loop
  logic [2:0] pin_raw;
  logic [2:0] pin_inv;
  logic [2:0] pin_cell;

  // configuration views
  logic row3_alt_function;
  logic row0_alt_function;
  logic invert_in_a;
  logic invert_in_b;
  logic invert_in_c;
  logic invert_out;
  logic flipflop_force_set;
  logic flipflop_force_clear;
  logic out_debounce_bypass;
  logic logic_event_en;
  logic logic_int_level;

  // field decode of the stored registers
  // reserved bits are masked on write, so no guard is needed here
  always_comb begin
    invert_out = st_r.func_cfg[logic_block_pkg::INV_OUT_BIT];
    invert_in_c = st_r.func_cfg[logic_block_pkg::INV_C_BIT];
    invert_in_b = st_r.func_cfg[logic_block_pkg::INV_B_BIT];
    invert_in_a = st_r.func_cfg[logic_block_pkg::INV_A_BIT];
    sel = st_r.func_cfg[logic_block_pkg::SEL_LSB +: logic_block_pkg::SEL_W];
    flipflop_force_set = st_r.ff_ctrl[logic_block_pkg::FLIPFLOP_FORCE_SET_BIT];
    flipflop_force_clear = st_r.ff_ctrl[logic_block_pkg::FLIPFLOP_FORCE_CLEAR_BIT];
    out_debounce_bypass = st_r.evt_cfg[logic_block_pkg::DBNC_BYP_BIT];
    logic_event_en = st_r.evt_cfg[logic_block_pkg::EVT_EN_BIT];
    logic_int_level = st_r.evt_cfg[logic_block_pkg::INT_LVL_BIT];
    row3_alt_function = st_r.pin_cfg_c[logic_block_pkg::ROW3_ALT_BIT];
    row0_alt_function = st_r.pin_cfg_c[logic_block_pkg::ROW0_ALT_BIT];
  end

  // input c source; the row-3 pad only counts once its extension bit is set
  always_comb begin
    in_c_raw = row3_alt_function ? row3_pin_in : logic_in_c;
  end

  // inputs and their inversion bits gathered in cell order a, b, c
  assign pin_raw = {in_c_raw, logic_in_b, logic_in_a};
  assign pin_inv = {invert_in_c, invert_in_b, invert_in_a};

  // one inverter per input, each steered by its own bit
  for (genvar i = 0; i < 3; i++) begin : g_in_inv
    assign pin_cell[i] = pin_raw[i] ^ pin_inv[i];
  end

  // named views used by the function mux and the flip-flop
  assign in_a = pin_cell[0];
  assign in_b = pin_cell[1];
  assign in_c = pin_cell[2];

  // function mux; the and/or/xor use all three inputs
  // sel 100 reads the cell flip-flop, never a combinational path
  always_comb begin
    case (logic_block_pkg::sel_t'(sel))
      logic_block_pkg::SEL_OFF: cell_raw = 1'b0;
      logic_block_pkg::SEL_AND: cell_raw = in_a & in_b & in_c;
      logic_block_pkg::SEL_OR: cell_raw = in_a | in_b | in_c;
      logic_block_pkg::SEL_XOR: cell_raw = in_a ^ in_b ^ in_c;
      logic_block_pkg::SEL_FLIP_FLOP: cell_raw = st_r.ff_q;
      logic_block_pkg::SEL_PASS_A: cell_raw = in_a;
      logic_block_pkg::SEL_PASS_B: cell_raw = in_b;
      logic_block_pkg::SEL_PASS_C: cell_raw = in_c;
      default: cell_raw = 1'b0;
    endcase
    cell_val = cell_raw ^ invert_out;
  end

  // readback mux; reserved bits and unmapped offsets read zero
  always_comb begin
    if (reg_addr == logic_block_pkg::ADDR_FUNC_CFG) begin
      rd_mux = st_r.func_cfg;
    end else if (reg_addr == logic_block_pkg::ADDR_FF_CTRL) begin
      rd_mux = st_r.ff_ctrl;
    end else if (reg_addr == logic_block_pkg::ADDR_EVT_CFG) begin
      rd_mux = st_r.evt_cfg;
    end else if (reg_addr == logic_block_pkg::ADDR_PIN_CFG_C) begin
      rd_mux = st_r.pin_cfg_c;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // debounce stage between the cell and the event logic
  // the bypass still goes through the stage's flop, so the bypass path
  // keeps a two-clock lag behind logic_out; the debounced path lags longer
  out_debounce #(
    .CYCLES(DBNC_CYCLES),
    .CNT_W(DBNC_CNT_W)
  ) u_dbnc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(st_r.cell_out),
    .bypass(out_debounce_bypass),
    .dout(dbnc_out)
  );

  // level compared against the chosen interrupt polarity
  always_comb begin
    out_active = (st_r.filt_q == logic_int_level);
  end

  // next-state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt_valid = 1'b0;
    st_nxt.rvalid = 1'b0;

    // register writes, only implemented bits stored
    // writes to unmapped offsets fall through and change nothing
    if (reg_wr) begin
      if (reg_addr == logic_block_pkg::ADDR_FUNC_CFG) begin
        st_nxt.func_cfg = reg_wdata & logic_block_pkg::FUNC_CFG_MASK;
      end else if (reg_addr == logic_block_pkg::ADDR_FF_CTRL) begin
        st_nxt.ff_ctrl = reg_wdata & logic_block_pkg::FF_CTRL_MASK;
      end else if (reg_addr == logic_block_pkg::ADDR_EVT_CFG) begin
        st_nxt.evt_cfg = reg_wdata & logic_block_pkg::EVT_CFG_MASK;
      end else if (reg_addr == logic_block_pkg::ADDR_PIN_CFG_C) begin
        st_nxt.pin_cfg_c = reg_wdata & logic_block_pkg::PIN_CFG_C_MASK;
      end
    end

    // read answer one cycle after the strobe
    if (reg_rd) begin
      st_nxt.rdata = rd_mux;
      st_nxt.rvalid = 1'b1;
    end

    // cell flip-flop: data from a, clocked by rising b; controls are levels
    // a control bit left at 1 overrides every b edge until software clears it
    st_nxt.b_prev = in_b;
    if (flipflop_force_clear) begin
      st_nxt.ff_q = 1'b0;
    end else if (flipflop_force_set) begin
      st_nxt.ff_q = 1'b1;
    end else if (in_b && !st_r.b_prev) begin
      st_nxt.ff_q = in_a;
    end

    // registered cell output
    st_nxt.cell_out = cell_val;
    st_nxt.filt_q = dbnc_out;

    // pad routing for row 0
    // the cell copy is taken before the output register, so pad and
    // logic_out change on the same edge
    if (row0_alt_function) begin
      st_nxt.row0_out = cell_val;
      st_nxt.row0_oe = 1'b1;
    end else begin
      st_nxt.row0_out = gpio1_out;
      st_nxt.row0_oe = gpio1_oe;
    end

    // event tracker: edges into and out of the active level
    // with level 0 the low idle output counts as active, so the tracker
    // leaves reset heading for active; no event unless enabled
    case (st_r.evt)
      logic_block_pkg::EVT_IDLE: begin
        if (out_active) begin
          st_nxt.evt = logic_block_pkg::EVT_ACTIVE;
          st_nxt.evt_valid = logic_event_en;
          st_nxt.evt_active = 1'b1;
        end
      end
      logic_block_pkg::EVT_ACTIVE: begin
        if (!out_active) begin
          st_nxt.evt = logic_block_pkg::EVT_IDLE;
          st_nxt.evt_valid = logic_event_en;
          st_nxt.evt_active = 1'b0;
        end
      end
      default: begin
        st_nxt.evt = logic_block_pkg::EVT_IDLE;
      end
    endcase

    // interrupt request held while enabled and at the active level
    // a level, not a pulse: it drops as soon as enable or level goes away
    st_nxt.irq = logic_event_en & out_active;
  end

  // single state register; tracker starts idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.func_cfg <= logic_block_pkg::FUNC_CFG_RST;
      st_r.ff_ctrl <= logic_block_pkg::FF_CTRL_RST;
      st_r.evt_cfg <= logic_block_pkg::EVT_CFG_RST;
      st_r.pin_cfg_c <= logic_block_pkg::PIN_CFG_C_RST;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.ff_q <= 1'b0;
      st_r.b_prev <= 1'b0;
      st_r.cell_out <= 1'b0;
      st_r.filt_q <= 1'b0;
      st_r.evt <= logic_block_pkg::EVT_IDLE;
      st_r.evt_valid <= 1'b0;
      st_r.evt_active <= 1'b0;
      st_r.irq <= 1'b0;
      st_r.row0_out <= 1'b0;
      st_r.row0_oe <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // register port answer, straight from the state register
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;

  // row-0 pad drive
  assign row0_pin_out = st_r.row0_out;
  assign row0_pin_oe = st_r.row0_oe;

  // cell output and event side
  assign logic_out = st_r.cell_out;
  assign logic_filtered = st_r.filt_q;
  assign event_valid = st_r.evt_valid;
  assign event_active = st_r.evt_active;
  assign int_req = st_r.irq;

endmodule // programmable_logic_block

// File: src/logic_block_pkg.sv
package logic_block_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ADDR_FUNC_CFG = 8'h36;
  localparam logic [7:0] ADDR_FF_CTRL = 8'h37;
  localparam logic [7:0] ADDR_EVT_CFG = 8'h38;
  localparam logic [7:0] ADDR_PIN_CFG_C = 8'h3c;

  // logic_function_config fields
  localparam int INV_OUT_BIT = 6;
  localparam int INV_C_BIT = 5;
  localparam int INV_B_BIT = 4;
  localparam int INV_A_BIT = 3;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;

  // logic_flipflop_control fields
  localparam int FLIPFLOP_FORCE_SET_BIT = 1;
  localparam int FLIPFLOP_FORCE_CLEAR_BIT = 0;

  // logic_event_interrupt_config fields
  localparam int DBNC_BYP_BIT = 2;
  localparam int EVT_EN_BIT = 1;
  localparam int INT_LVL_BIT = 0;

  // pin configuration c fields owned here
  localparam int ROW3_ALT_BIT = 3;
  localparam int ROW0_ALT_BIT = 0;

  // implemented bits per register, reserved bits read zero
  localparam logic [7:0] FUNC_CFG_MASK = 8'h7f;
  localparam logic [7:0] FF_CTRL_MASK = 8'h03;
  localparam logic [7:0] EVT_CFG_MASK = 8'h07;
  localparam logic [7:0] PIN_CFG_C_MASK = 8'h09;

  // reset values
  localparam logic [7:0] FUNC_CFG_RST = 8'h00;
  localparam logic [7:0] FF_CTRL_RST = 8'h00;
  localparam logic [7:0] EVT_CFG_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_C_RST = 8'h00;

  // cell function select codes
  typedef enum logic [2:0] {
    SEL_OFF = 3'h0,
    SEL_AND = 3'h1,
    SEL_OR = 3'h2,
    SEL_XOR = 3'h3,
    SEL_FLIP_FLOP = 3'h4,
    SEL_PASS_A = 3'h5,
    SEL_PASS_B = 3'h6,
    SEL_PASS_C = 3'h7
  } sel_t;

  // event tracker states, one-hot
  typedef enum logic [1:0] {
    EVT_IDLE = 2'b01,
    EVT_ACTIVE = 2'b10
  } evt_state_t;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DBNC_TIME_NS = 1000;
  localparam int DBNC_CYCLES = (DBNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: src/out_debounce.sv
module out_debounce #(
  parameter int CYCLES = logic_block_pkg::DBNC_CYCLES,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // raw level and control
  input wire logic din,
  input wire logic bypass,
  // filtered level
  output logic dout
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic stable;
  } dbnc_state_t;

  dbnc_state_t st_r;
  dbnc_state_t st_nxt;

  // with bypass clear, a new level is only accepted after it has held for CYCLES clocks
  always_comb begin
    st_nxt = st_r;
    if (bypass) begin
      st_nxt.stable = din; // glitches pass straight through
      st_nxt.cnt = '0;
    end else if (din == st_r.stable) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CNT_W'(CYCLES - 1)) begin
      st_nxt.stable = din;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stable;

endmodule // out_debounce

// File: dv/reg_host_model.sv
module reg_host_model (
  // clock
  input wire logic ref_clk,
  // register strobes toward the device
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_rd = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // one strobe cycle; address and data flip once released so stale values never look valid
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
  endtask
endmodule // reg_host_model

// File: dv/logic_block_assertions.sv
module logic_block_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register writes
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  // pins and cell side
  input wire logic logic_in_a,
  input wire logic logic_in_b,
  input wire logic logic_in_c,
  input wire logic row3_pin_in,
  input wire logic gpio1_out,
  input wire logic gpio1_oe,
  input wire logic row0_pin_out,
  input wire logic row0_pin_oe,
  input wire logic logic_out,
  input wire logic logic_filtered,
  input wire logic event_valid,
  input wire logic event_active,
  input wire logic int_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] f_r, e_r, p_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // shadow copies, outputs are judged against what was written
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      f_r <= 8'h00;
      e_r <= 8'h00;
      p_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h36) f_r <= reg_wdata;
      if (reg_addr == 8'h38) e_r <= reg_wdata;
      if (reg_addr == 8'h3c) p_r <= reg_wdata;
    end
  end

  property p_row_alt;
    p_r[0] && $past(p_r[0]) |-> row0_pin_oe && row0_pin_out == logic_out;
  endproperty
  a_row_alt: assert property (p_row_alt) else $error("row0 not cell");
  property p_row_gpio;
    $past(rstn) && !p_r[0] && !$past(p_r[0]) |->
      {row0_pin_oe, row0_pin_out} == $past({gpio1_oe, gpio1_out});
  endproperty
  a_row_gpio: assert property (p_row_gpio) else $error("row0 not gpio");
  property p_evt_off;
    !e_r[1] && !$past(e_r[1]) |-> !event_valid && !int_req;
  endproperty
  a_evt_off: assert property (p_evt_off) else $error("event while off");
  property p_bypass;
    e_r[2] && $past(e_r[2], 3) && $changed(logic_out) |-> ##2 logic_filtered == $past(logic_out, 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass lag");
  property p_dbnc;
    !e_r[2] && !$past(e_r[2], 6) && $rose(logic_filtered) |->
      $past(logic_out, 2) && $past(logic_out, 3) && $past(logic_out, 4) && $past(logic_out, 5);
  endproperty
  a_dbnc: assert property (p_dbnc) else $error("short level passed");
  property p_int_lvl;
    $stable(e_r) |-> int_req == (e_r[1] && $past(logic_filtered) == e_r[0]);
  endproperty
  a_int_lvl: assert property (p_int_lvl) else $error("int level");
  property p_evt_edge;
    event_valid |-> $past(e_r[1]) && event_active == ($past(logic_filtered) == $past(e_r[0]));
  endproperty
  a_evt_edge: assert property (p_evt_edge) else $error("event kind");
  property p_out_inv;
    $changed(f_r[6]) && $stable(f_r[5:0]) && $stable(p_r) && f_r[1:0] != 2'h0 &&
      $stable({logic_in_a, logic_in_b, logic_in_c, row3_pin_in}) |=> $changed(logic_out);
  endproperty
  a_out_inv: assert property (p_out_inv) else $error("out not inverted");
  c_ev: cover property (event_valid && event_active);
  c_int: cover property (int_req);
  c_alt: cover property (row0_pin_oe && p_r[0]);
endmodule // logic_block_checker

bind programmable_logic_block logic_block_checker u_chk (.*);

// File: dv/programmable_logic_block_tb.sv
module programmable_logic_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg, pc;
  logic reg_wr, reg_rd, reg_rvalid, row0_pin_out, row0_pin_oe;
  logic logic_out, logic_filtered, event_valid, event_active, int_req;
  logic logic_in_a = 1'b0, logic_in_b = 1'b0, logic_in_c = 1'b0;
  logic row3_pin_in = 1'b0, gpio1_out = 1'b0, gpio1_oe = 1'b0;
  logic [7:0] rq[$];
  logic eq[$];
  logic [7:0] adr[5] = '{8'h36, 8'h37, 8'h38, 8'h3c, 8'h40};
  logic [7:0] wv[5] = '{8'hff, 8'hff, 8'hfc, 8'hff, 8'hff};
  logic [7:0] msk[5] = '{8'h7f, 8'h03, 8'h04, 8'h09, 8'h00};
  int n_errors = 0;
  int n_compared = 0;

  // 125 MHz
  always #4 ref_clk = ~ref_clk;
  reg_host_model u_host (.*);
  // short debounce keeps the run brief
  programmable_logic_block #(.DBNC_CYCLES(4)) u_dut (.*);

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    u_host.acc(1'b0, a, 8'h00);
  endtask
  task automatic step(input logic v, input int n);
    logic_in_a = v;
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // cell value worked out from the present inputs and routing
  function automatic logic fexp(input logic [7:0] f);
    logic [2:0] v;
    logic [7:0] t;
    v = {pc[3] ? row3_pin_in : logic_in_c, logic_in_b, logic_in_a} ^ f[5:3];
    t = {v[2], v[1], v[0], 1'b0, ^v, |v, &v, 1'b0};
    return t[f[2:0]] ^ f[6];
  endfunction

  // oldest note against each answer and each event
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1) cmp8(reg_rdata, rq.size() > 0 ? rq.pop_front() : 8'hxx);
    if (event_valid === 1'b1) cmp1(event_active, eq.size() > 0 ? eq.pop_front() : 1'bx);
  end

  initial begin
    void'($urandom(93968));
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    // reset values, then all ones except fc at 38: reserved and unmapped bits read zero
    foreach (adr[i]) rd(adr[i], 8'h00);
    foreach (adr[i]) begin
      wr(adr[i], wv[i]);
      rd(adr[i], msk[i]);
    end
    foreach (adr[i]) wr(adr[i], 8'h00);
    // random mux, inversion and pin routing
    repeat (24) begin
      cfg = 8'($urandom) & 8'h7f;
      pc = 8'($urandom) & 8'h09;
      if (cfg[2:0] == 3'h4) cfg[2:0] = 3'h0;
      wr(8'h3c, pc);
      wr(8'h36, cfg);
      {logic_in_a, logic_in_b, logic_in_c, row3_pin_in, gpio1_out, gpio1_oe} = 6'($urandom);
      repeat (2) @(negedge ref_clk);
      cmp1(logic_out, fexp(cfg));
      cmp1(row0_pin_oe, pc[0] | gpio1_oe);
      cmp1(row0_pin_out, pc[0] ? fexp(cfg) : gpio1_out);
      wr(8'h36, cfg ^ 8'h40);
      repeat (2) @(negedge ref_clk);
      cmp1(logic_out, fexp(cfg ^ 8'h40));
    end
    // flip-flop: forced set, forced clear, then clocked by input b
    wr(8'h3c, 8'h00);
    wr(8'h36, 8'h04);
    wr(8'h37, 8'h02);
    repeat (3) @(negedge ref_clk);
    cmp1(logic_out, 1'b1);
    wr(8'h37, 8'h01);
    repeat (3) @(negedge ref_clk);
    cmp1(logic_out, 1'b0);
    wr(8'h37, 8'h00);
    for (int i = 1; i >= 0; i--) begin
      {logic_in_a, logic_in_b} = {i[0], 1'b0};
      repeat (3) @(negedge ref_clk);
      logic_in_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      cmp1(logic_out, i[0]);
    end
    // events: bypassed, level flipped, debounced with a glitch, then disabled
    wr(8'h36, 8'h05);
    step(1'b0, 12);
    wr(8'h38, 8'h05);
    wr(8'h38, 8'h07);
    eq = {eq, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    step(1'b1, 3);
    cmp1(logic_filtered, 1'b1);
    step(1'b1, 9);
    cmp1(int_req, 1'b1);
    step(1'b0, 12);
    wr(8'h38, 8'h06);
    step(1'b1, 12);
    wr(8'h38, 8'h03);
    step(1'b0, 1);
    step(1'b1, 2);
    cmp1(logic_filtered, 1'b1);
    step(1'b1, 10);
    eq = {eq, 1'b0};
    step(1'b0, 16);
    wr(8'h38, 8'h01);
    step(1'b1, 3);
    cmp1(logic_filtered, 1'b0);
    step(1'b1, 13);
    cmp1(int_req, 1'b0);
    step(1'b0, 16);
    cmp8(8'(eq.size()), 8'h00);
    final_report();
  end

  // hang guard, the sequence needs well under 2000 cycles
  initial begin
    #50us;
    n_errors++;
    final_report();
  end
endmodule // programmable_logic_block_tb
